// [verilog/cpr_top.sv]
// configuration memory read-out: storage, address counter, cascade and test port
// ==========================================================
`timescale 1ns/1ps

module cpr_top #(
  parameter int DEPTH      = cpr_pkg::DEPTH_DEF,
  parameter int ADDR_W     = $clog2(DEPTH),
  parameter bit SHARED_PIN = 1'b0
) (
  // system clock and reset
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  // storage fill port
  input  wire logic               prog_we,
  input  wire logic [ADDR_W-1:0]  prog_addr,
  input  wire logic [7:0]         prog_data,
  // load link
  input  wire logic               load_clock,
  input  wire logic               chip_enable_n,
  input  wire logic               byte_wide_mode_b,
  input  wire logic               hold_n_in,
  output cpr_pkg::cpr_od_t        hold_n_pin,
  output cpr_pkg::cpr_data_t      parallel_data_out,
  output logic                    cascade_enable_out_n,
  output cpr_pkg::cpr_od_t        load_restart_out_n,
  // test access port
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output cpr_pkg::cpr_od_t        tdo_pin
);
  import cpr_pkg::*;

  localparam int CW = ADDR_W + 3;

  // ==========================================================
  // system domain: reset release, own reset hold, restart pulse
  logic               rst_s1_ff;
  logic               rst_n_ff;
  logic [TIMER_W-1:0] busy_cnt_ff;
  logic [TIMER_W-1:0] nxt_busy_cnt;
  logic               busy_ff;
  logic               nxt_busy;
  logic               tgl_s1_ff;
  logic               tgl_s2_ff;
  logic               tgl_s3_ff;
  logic [TIMER_W-1:0] pulse_cnt_ff;
  logic [TIMER_W-1:0] nxt_pulse_cnt;
  logic               mode_s1_ff;
  logic               mode_s2_ff;
  logic               cfg_tgl_ff;
  logic [7:0]         mem [DEPTH];

  // reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // own reset timer and restart pulse timer
  always_comb begin
    nxt_busy_cnt  = busy_cnt_ff;
    nxt_pulse_cnt = pulse_cnt_ff;
    if (busy_cnt_ff != '0) begin
      nxt_busy_cnt = busy_cnt_ff - 1'b1;
    end
    if (tgl_s2_ff != tgl_s3_ff) begin
      nxt_pulse_cnt = TIMER_W'(RESTART_PULSE_CYC);
    end else if (pulse_cnt_ff != '0) begin
      nxt_pulse_cnt = pulse_cnt_ff - 1'b1;
    end
    nxt_busy = (nxt_busy_cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      busy_cnt_ff  <= TIMER_W'(RESET_HOLD_CYC);
      busy_ff      <= 1'b1;
      pulse_cnt_ff <= '0;
      tgl_s1_ff    <= 1'b0;
      tgl_s2_ff    <= 1'b0;
      tgl_s3_ff    <= 1'b0;
      mode_s1_ff   <= 1'b0;
      mode_s2_ff   <= 1'b0;
    end else begin
      busy_cnt_ff  <= nxt_busy_cnt;
      busy_ff      <= nxt_busy;
      pulse_cnt_ff <= nxt_pulse_cnt;
      tgl_s1_ff    <= cfg_tgl_ff;
      tgl_s2_ff    <= tgl_s1_ff;
      tgl_s3_ff    <= tgl_s2_ff;
      mode_s1_ff   <= byte_wide_mode_b;
      mode_s2_ff   <= mode_s1_ff;
    end
  end

  // storage fill, read from the link side as a dual-clock array
  always_ff @(posedge sys_clk) begin
    if (prog_we) begin
      mem[prog_addr] <= prog_data;
    end
  end

  // open-drain pins only ever pull low
  assign hold_n_pin.o          = 1'b0;
  assign hold_n_pin.oe         = busy_ff;
  assign load_restart_out_n.o  = 1'b0;
  // on the shared small-package pin the restart drive yields to data bit 4
  assign load_restart_out_n.oe = (pulse_cnt_ff != '0)
                                 && !(SHARED_PIN && mode_s2_ff);

  // ==========================================================
  // link domain: address counter on the load clock
  logic          link_clr;
  logic          lmode_s1_ff;
  logic          lmode_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          past_ff;
  logic          nxt_past;
  logic          at_last;
  logic [CW-1:0] step;
  logic [7:0]    word;
  logic          serial_data_out;
  logic          drive;

  // pins clear the counter at once, without waiting for a clock edge
  assign link_clr = chip_enable_n | ~hold_n_in | busy_ff;

  // mode strap crossing, reset only by the device's own reset
  always_ff @(posedge load_clock or posedge busy_ff) begin
    if (busy_ff) begin
      lmode_s1_ff <= 1'b0;
      lmode_ff    <= 1'b0;
    end else begin
      lmode_s1_ff <= byte_wide_mode_b;
      lmode_ff    <= lmode_s1_ff;
    end
  end

  // byte mode steps one whole byte, serial mode one bit
  assign step    = lmode_ff ? CW'(8) : CW'(1);
  assign at_last = lmode_ff ? (&cnt_ff[CW-1:3]) : (&cnt_ff);

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_past = past_ff;
    if (!past_ff) begin
      if (at_last) begin
        nxt_past = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + step;
      end
    end
  end

  always_ff @(posedge load_clock or posedge link_clr) begin
    if (link_clr) begin
      cnt_ff  <= '0;
      past_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      past_ff <= nxt_past;
    end
  end

  // data follows the counter, so address zero shows before the first edge
  assign word            = mem[cnt_ff[CW-1:3]];
  assign serial_data_out = word[LAST_BIT - cnt_ff[2:0]];
  assign drive           = ~link_clr & ~past_ff;

  // data pins float when held, in standby or once handed on
  always_comb begin
    parallel_data_out.d  = lmode_ff ? word : {7'h00, serial_data_out};
    parallel_data_out.oe = 8'h00;
    if (drive) begin
      parallel_data_out.oe = lmode_ff ? BYTE_OE : SERIAL_OE;
    end
  end

  // cascade enable to the next memory
  assign cascade_enable_out_n = ~(past_ff & ~chip_enable_n & hold_n_in);

  // ==========================================================
  // test access port on the test clock
  cpr_tap_t       tap_ff;
  cpr_tap_t       nxt_tap;
  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] nxt_ir_sh;
  logic [IR_W-1:0] ir_ff;
  logic [IR_W-1:0] nxt_ir;
  logic            byp_ff;
  logic            nxt_byp;
  logic            nxt_tgl;
  logic            tdo_ff;
  logic            nxt_tdo;
  logic            tdo_oe_ff;
  logic            nxt_tdo_oe;
  logic            tap_rst;

  assign tap_rst = ~rst_n_ff;

  // controller state from mode select
  always_comb begin
    case (tap_ff)
      TAP_TLR:    nxt_tap = tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    nxt_tap = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: nxt_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  nxt_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nxt_tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nxt_tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nxt_tap = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nxt_tap = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: nxt_tap = tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: nxt_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  nxt_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nxt_tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nxt_tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nxt_tap = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nxt_tap = tms ? TAP_SEL_DR : TAP_RTI;
      default:    nxt_tap = TAP_TLR;
    endcase
  end

  // instruction and bypass registers, start instruction as a toggle
  always_comb begin
    nxt_ir_sh = ir_sh_ff;
    nxt_ir    = ir_ff;
    nxt_byp   = byp_ff;
    nxt_tgl   = cfg_tgl_ff;
    case (tap_ff)
      TAP_TLR:    nxt_ir = IR_RESET;
      TAP_CAP_IR: nxt_ir_sh = IR_CAPTURE;
      TAP_SH_IR:  nxt_ir_sh = {tdi, ir_sh_ff[IR_W-1:1]};
      TAP_UPD_IR: begin
        nxt_ir = ir_sh_ff;
        if (ir_sh_ff == IR_CONFIG) begin
          nxt_tgl = ~cfg_tgl_ff;
        end
      end
      TAP_CAP_DR: nxt_byp = 1'b0;
      TAP_SH_DR:  nxt_byp = tdi;
      default:    nxt_byp = byp_ff;
    endcase
  end

  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      tap_ff     <= TAP_TLR;
      ir_sh_ff   <= IR_CAPTURE;
      ir_ff      <= IR_RESET;
      byp_ff     <= 1'b0;
      cfg_tgl_ff <= 1'b0;
    end else begin
      tap_ff     <= nxt_tap;
      ir_sh_ff   <= nxt_ir_sh;
      ir_ff      <= nxt_ir;
      byp_ff     <= nxt_byp;
      cfg_tgl_ff <= nxt_tgl;
    end
  end

  // serial out changes on the falling edge, floats outside shifting
  always_comb begin
    nxt_tdo    = (tap_ff == TAP_SH_IR) ? ir_sh_ff[0] : byp_ff;
    nxt_tdo_oe = (tap_ff == TAP_SH_IR) || (tap_ff == TAP_SH_DR);
  end

  always_ff @(negedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_ff    <= 1'b1;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo_pin.o  = tdo_ff;
  assign tdo_pin.oe = tdo_oe_ff;

endmodule

// [verilog/cpr_pkg.sv]
// constants and types shared by the configuration memory read-out block
package cpr_pkg;
  // ==========================================================
  // timing
  localparam int SYS_PERIOD_NS     = 20;
  localparam int RESET_HOLD_NS     = 1000;
  localparam int RESET_HOLD_CYC    = (RESET_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int RESTART_PULSE_NS  = 1000;
  localparam int RESTART_PULSE_CYC = (RESTART_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TIMER_W           = 8;
  localparam int LOAD_CLK_MAX_MHZ  = 15;

  // ==========================================================
  // storage and pins
  localparam int         DEPTH_DEF   = 16384;
  localparam int         SHARED_BIT  = 4;
  localparam logic [7:0] SERIAL_OE   = 8'h01;
  localparam logic [7:0] BYTE_OE     = 8'hff;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // ==========================================================
  // test access port
  localparam int         IR_W       = 8;
  localparam logic [7:0] IR_CONFIG  = 8'hee;
  localparam logic [7:0] IR_BYPASS  = 8'hff;
  localparam logic [7:0] IR_CAPTURE = 8'h01;
  localparam logic [7:0] IR_RESET   = IR_BYPASS;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic o;
    logic oe;
  } cpr_od_t;

  typedef struct packed {
    logic [7:0] d;
    logic [7:0] oe;
  } cpr_data_t;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } cpr_tap_t;
endpackage

// [test/cpr_top_chk.sv]
// pin-level assertions for the configuration memory read-out block
`timescale 1ns/1ps
module cpr_top_chk (
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          arst_n,
  // load link pins
  input wire logic          chip_enable_n,
  input wire logic          byte_wide_mode_b,
  input wire logic          hold_n_in,
  input cpr_pkg::cpr_od_t   hold_n_pin,
  input cpr_pkg::cpr_data_t parallel_data_out,
  input wire logic          cascade_enable_out_n,
  input cpr_pkg::cpr_od_t   load_restart_out_n
);
  import cpr_pkg::*;
  // ==========================================================
  // checks on the system clock
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // counts how long the restart line has been pulled so far
  logic [7:0] pulse_len_ff;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_len_ff <= 8'h00;
    end else begin
      pulse_len_ff <= load_restart_out_n.oe ? pulse_len_ff + 8'h01 : 8'h00;
    end
  end

  restart_len_a: assert property ($fell(load_restart_out_n.oe) |-> pulse_len_ff == 8'(RESTART_PULSE_CYC))
    else $error("restart pulse length wrong");
  float_standby_a: assert property (chip_enable_n |-> parallel_data_out.oe == 8'h00)
    else $error("data driven in standby");
  float_hold_a: assert property (!hold_n_in |-> parallel_data_out.oe == 8'h00)
    else $error("data driven while held");
  casc_standby_a: assert property (chip_enable_n |-> cascade_enable_out_n)
    else $error("cascade low in standby");
  casc_hold_a: assert property (!hold_n_in |-> cascade_enable_out_n)
    else $error("cascade low while held");
  casc_past_a: assert property (!cascade_enable_out_n |-> parallel_data_out.oe == 8'h00)
    else $error("data driven past last word");
  hold_drain_a: assert property (hold_n_pin.oe |-> !hold_n_pin.o)
    else $error("hold line driven high");
  restart_drain_a: assert property (load_restart_out_n.oe |-> !load_restart_out_n.o)
    else $error("restart line driven high");
  restart_pulse_a: assert property ($rose(load_restart_out_n.oe) |-> load_restart_out_n.oe [*8])
    else $error("restart pulse too short");
  drive_width_a: assert property (parallel_data_out.oe != 8'h00 |->
    parallel_data_out.oe == (byte_wide_mode_b ? BYTE_OE : SERIAL_OE))
    else $error("wrong data lines driven");

  // main scenarios
  cv_cascade: cover property ($fell(cascade_enable_out_n));
  cv_restart: cover property ($rose(load_restart_out_n.oe));
  cv_byte: cover property (parallel_data_out.oe == BYTE_OE);
endmodule

bind cpr_top cpr_top_chk chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .chip_enable_n(chip_enable_n),
  .byte_wide_mode_b(byte_wide_mode_b), .hold_n_in(hold_n_in), .hold_n_pin(hold_n_pin),
  .parallel_data_out(parallel_data_out), .cascade_enable_out_n(cascade_enable_out_n),
  .load_restart_out_n(load_restart_out_n));

// [test/cpr_load_host.sv]
// receiving logic device model: makes the load clock in frames and captures data
`timescale 1ns/1ps
module cpr_load_host (
  // load link
  output logic               load_clock,
  output logic               chip_enable_n,
  input  cpr_pkg::cpr_data_t data_in
);
  import cpr_pkg::*;
  logic [7:0] cap [0:15];
  // clock stands still low between frames
  initial begin
    load_clock = 1'b0;
    chip_enable_n = 1'b1;
  end
  // one pulse; data is taken just before the rising edge
  task automatic pulse(input int idx, input int hp);
    #hp;
    if (idx >= 0) cap[idx] = data_in.d;
    load_clock = 1'b1;
    #hp;
    load_clock = 1'b0;
  endtask
  // serial frames use a slower clock to stay under its limit
  // two settle edges in standby, then exactly n counting edges
  task automatic frame(input int n, input int hp);
    chip_enable_n = 1'b1;
    pulse(-1, hp);
    pulse(-1, hp);
    chip_enable_n = 1'b0;
    for (int i = 0; i < n; i++) pulse(i, hp);
  endtask
  // back to standby
  task automatic stop();
    chip_enable_n = 1'b1;
  endtask
endmodule

// [test/cpr_top_bench.sv]
// self-checking bench for the configuration memory read-out block
`timescale 1ns/1ps
module cpr_top_bench;
  import cpr_pkg::*;
  typedef struct {logic mode; int n; int hp;} cpr_row_t;
  logic       sys_clk, arst_n, prog_we, prog_addr, byte_wide_mode_b, hold_drv, tck, tms, tdi, o;
  logic [7:0] prog_data, got;
  logic [7:0] memv [0:1] = '{8'ha5, 8'h3c};
  logic       load_clock, chip_enable_n, hold_n_in, cascade_enable_out_n;
  cpr_od_t    hold_n_pin, load_restart_out_n, tdo_pin;
  cpr_data_t  parallel_data_out;
  int         fails = 0, checked = 0, cyc = 0, k, rlen = 0;
  cpr_row_t   rows [0:1] = '{'{1'b0, 16, 35}, '{1'b1, 2, 15}};

  // open-drain hold line with pull-up
  assign hold_n_in = hold_drv & ~(hold_n_pin.oe & ~hold_n_pin.o);

  cpr_top #(.DEPTH(2)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .load_clock(load_clock), .chip_enable_n(chip_enable_n),
    .byte_wide_mode_b(byte_wide_mode_b), .hold_n_in(hold_n_in), .hold_n_pin(hold_n_pin),
    .parallel_data_out(parallel_data_out), .cascade_enable_out_n(cascade_enable_out_n),
    .load_restart_out_n(load_restart_out_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_pin(tdo_pin));
  cpr_load_host host_u (.load_clock(load_clock), .chip_enable_n(chip_enable_n),
    .data_in(parallel_data_out));

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask
  // one test clock; tdo read with its pull-up before the rise
  task automatic tap(input logic m, input logic i);
    tms = m;
    tdi = i;
    repeat (5) @(negedge sys_clk);
    o = tdo_pin.oe ? tdo_pin.o : 1'b1;
    tck = 1'b1;
    repeat (5) @(negedge sys_clk);
    tck = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // restart pulse length and timeout
  // sampled on the falling edge, away from the edge that moves the pin
  always @(negedge sys_clk) begin
    cyc++;
    if (load_restart_out_n.oe === 1'b1) rlen++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {arst_n, prog_we, prog_addr, prog_data, byte_wide_mode_b, tck} = '0;
    {hold_drv, tms, tdi} = '1;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    k = 0;
    repeat (5) @(negedge sys_clk);
    chk("hold line", 8'h00, {7'h0, hold_n_in});
    while (hold_n_pin.oe === 1'b1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    chk("hold length", 8'h01, {7'h0, k >= RESET_HOLD_CYC - 5 && k <= RESET_HOLD_CYC});
    $display("test reset done");
    for (int a = 0; a < 2; a++) begin
      prog_we = 1'b1;
      prog_addr = a[0];
      prog_data = memv[a];
      @(negedge sys_clk);
    end
    prog_we = 1'b0;
    // ordinary frames, serial then byte-wide
    foreach (rows[r]) begin
      byte_wide_mode_b = rows[r].mode;
      repeat (4) @(negedge sys_clk);
      host_u.frame(rows[r].n, rows[r].hp);
      for (int i = 0; i < rows[r].n; i++) begin
        got = rows[r].mode ? memv[i] : {7'h0, memv[i / 8][7 - i % 8]};
        chk("captured", got, rows[r].mode ? host_u.cap[i] : {7'h0, host_u.cap[i][0]});
      end
      @(negedge sys_clk);
      chk("past last oe", 8'h00, parallel_data_out.oe);
      chk("cascade low", 8'h00, {7'h0, cascade_enable_out_n});
      host_u.stop();
      @(negedge sys_clk);
      chk("standby cascade", 8'h01, {7'h0, cascade_enable_out_n});
      $display("test row %0d done", r);
    end
    // hold pulled low in mid-stream
    byte_wide_mode_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    host_u.frame(5, 35);
    chk("mid bit", {7'h0, memv[0][2]}, {7'h0, parallel_data_out.d[0]});
    @(negedge sys_clk);
    hold_drv = 1'b0;
    @(negedge sys_clk);
    chk("held oe", 8'h00, parallel_data_out.oe);
    chk("held cascade", 8'h01, {7'h0, cascade_enable_out_n});
    hold_drv = 1'b1;
    @(negedge sys_clk);
    chk("first bit", {7'h0, memv[0][7]}, {7'h0, parallel_data_out.d[0]});
    chk("resumed oe", SERIAL_OE, parallel_data_out.oe);
    host_u.stop();
    $display("test hold abort done");
    // start instruction through the test port
    for (int j = 0; j < 5; j++) tap(1'(5'b00110 >> j), 1'b1);
    for (int j = 0; j < 8; j++) begin
      tap(j == 7, IR_CONFIG[j]);
      got[j] = o;
    end
    chk("ir capture", IR_CAPTURE, got);
    rlen = 0;
    tap(1'b1, 1'b1);
    tap(1'b0, 1'b1);
    repeat (80) @(negedge sys_clk);
    chk("restart length", 8'(RESTART_PULSE_CYC), 8'(rlen));
    $display("test restart done");
    wrap_up();
  end
endmodule
